// ===== intc_pkg.sv
// constants, vector map and register layout of the priority interrupt controller
// assumes one 200 MHz clock and a classic wishbone master for software access
// ****************************************************************************
// Notes on behaviour
// - vector entry holds low 16 handler bits; entry address is vector times four
// - exactly two control modes, 0 and 2, chosen by a control register field
// - mode 0 uses fixed default order; one mask bit masks all but nmi
// - a source requests only while its flag and enable are both one
// - mode 0: mask bit set accepts only nmi; clear accepts requests
// - mode 0: highest default-ranked request wins, others stay pending
// - handling starts only after the current instruction has completed
// - mode 0 pushes return pc then condition code register
// - mode 0 sets the condition code mask bit after stacking
// - after stacking read the vector entry and jump to the handler
// - mode 2 masks by comparing source level with three-bit mask level
// - mode 2 picks highest level; ties go to default order
// - mode 2 accepts only a level strictly above the mask level
// - mode 2 pushes return pc, condition code and extended control registers
// - mode 2 clears trace bit and loads mask level with accepted level
// - mode 2 accepting nmi sets the mask level to seven
// - default priority falls as vector number rises; fixed inside a module
// - nmi ranks highest, always accepted; edge polarity selectable
// ****************************************************************************

package intc_pkg;

  // ****************************************************************************
  // sources and vectors
  // ****************************************************************************
  localparam int NUM_SRC = 21;
  localparam int NUM_GRP = 6;
  localparam int LVL_W = 3;
  localparam int VEC_W = 8;
  localparam int IDX_W = 5;
  localparam int HANDLER_W = 16;
  localparam int VEC_SHIFT = 2;
  localparam logic [7:0] NMI_VECTOR = 8'h07;
  localparam logic [7:0] SRC_VECTOR [0:20] = '{
    8'h44, 8'h45, 8'h46,
    8'h48, 8'h49, 8'h4a, 8'h4b,
    8'h50, 8'h51, 8'h52, 8'h53,
    8'h54, 8'h55, 8'h56, 8'h57,
    8'h58, 8'h59, 8'h5a, 8'h5b,
    8'h68, 8'h69};
  localparam logic [2:0] SRC_GROUP [0:20] = '{
    3'h0, 3'h0, 3'h0,
    3'h1, 3'h1, 3'h1, 3'h1,
    3'h2, 3'h2, 3'h2, 3'h2,
    3'h3, 3'h3, 3'h3, 3'h3,
    3'h4, 3'h4, 3'h4, 3'h4,
    3'h5, 3'h5};
  localparam logic [2:0] NMI_MASK_LEVEL = 3'h7;

  // ****************************************************************************
  // register map
  // ****************************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CCR = 8'h04;
  localparam logic [7:0] REG_EXR = 8'h08;
  localparam logic [7:0] REG_PRIO = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_MASK = 8'h14;
  localparam logic [7:0] REG_INFO = 8'h18;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_NMI_EDGE_BIT = 2;
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam int CCR_I_BIT = 7;
  localparam int EXR_T_BIT = 7;
  localparam int PRIO_STRIDE = 4;
  localparam int STAT_W = 3;
  localparam int STAT_ACCEPT = 0;
  localparam int STAT_NMI = 1;
  localparam int STAT_HELD = 2;
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam logic [7:0] EXR_RESET = 8'h07;
  localparam logic [23:0] PRIO_RESET = 24'h000000;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] PUSH_PC = 2'h0;
  localparam logic [1:0] PUSH_CCR = 2'h1;
  localparam logic [1:0] PUSH_EXR = 2'h2;

endpackage

// ===== priority_interrupt_controller.sv
// priority interrupt controller with exception sequencing toward the core
// assumes peripheral flags and core strobes on clk; nmi pin asynchronous
//
// Our own choices: the Wishbone register port and the register addresses.

`timescale 1ns/1ps

module priority_interrupt_controller #(
  parameter int PC_W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic nmi_pin,
  input wire logic [intc_pkg::NUM_SRC-1:0] src_flag,
  input wire logic [intc_pkg::NUM_SRC-1:0] src_enable,
  input wire logic insn_done,
  input wire logic [PC_W-1:0] return_pc,
  output logic push_valid,
  output logic [1:0] push_kind,
  output logic [PC_W-1:0] push_data,
  output logic vec_rd_req,
  output logic [intc_pkg::HANDLER_W-1:0] vec_addr,
  input wire logic vec_rd_ack,
  input wire logic [intc_pkg::HANDLER_W-1:0] vec_rd_data,
  output logic jump_valid,
  output logic [intc_pkg::HANDLER_W-1:0] jump_addr,
  output logic irq
);

  typedef enum {
    ST_IDLE, ST_WAIT_INSN, ST_PUSH_PC, ST_PUSH_CCR, ST_PUSH_EXR, ST_MASK, ST_VEC
  } state_type;

  // ****************************************************************************
  // functions
  // ****************************************************************************
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] level_of(input logic [23:0] prio, input logic [2:0] g);
    return prio[intc_pkg::PRIO_STRIDE*g +: intc_pkg::LVL_W];
  endfunction

  // ****************************************************************************
  // state
  // ****************************************************************************
  state_type state_reg;
  logic [2:0] ctrl_reg;
  logic [7:0] ccr_reg;
  logic [7:0] exr_reg;
  logic [23:0] prio_reg;
  logic [intc_pkg::STAT_W-1:0] stat_reg;
  logic [intc_pkg::STAT_W-1:0] mask_reg;
  logic nmi_s1_reg, nmi_s2_reg, nmi_s3_reg, nmi_level_reg;
  logic nmi_pend_reg;
  logic acc_nmi_reg, acc_mode2_reg;
  logic [2:0] acc_lvl_reg;
  logic [7:0] acc_vec_reg;
  logic [PC_W-1:0] ret_pc_reg;
  logic ack_reg, push_valid_reg, vec_rd_req_reg, jump_valid_reg, irq_reg;
  logic [31:0] dat_reg;
  logic [1:0] push_kind_reg;
  logic [PC_W-1:0] push_data_reg;
  logic [intc_pkg::HANDLER_W-1:0] vec_addr_reg, jump_addr_reg;

  logic [intc_pkg::NUM_SRC-1:0] req;
  logic [intc_pkg::IDX_W-1:0] best_idx;
  logic [2:0] best_lvl;
  logic best_any;
  logic mode2, i_bit;
  logic [2:0] mask_lvl;
  logic accept_src, accept_any, nmi_edge;
  logic bus_req, bus_wr;
  logic [31:0] rd_value, wr_value, w1c_value;
  logic [intc_pkg::STAT_W-1:0] stat_set;

  assign mode2 = (ctrl_reg[1:0] == intc_pkg::MODE_2);
  assign i_bit = ccr_reg[intc_pkg::CCR_I_BIT];
  assign mask_lvl = exr_reg[2:0];
  assign req = src_flag & src_enable;

  // ****************************************************************************
  // arbitration
  // ****************************************************************************
  // scan from lowest rank so a lower vector overrides on an equal level
  always_comb begin
    logic [2:0] lv;
    lv = 3'h0;
    best_idx = '0;
    best_lvl = 3'h0;
    best_any = 1'b0;
    for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--) begin
      lv = mode2 ? level_of(prio_reg, intc_pkg::SRC_GROUP[i]) : 3'h0;
      if (req[i] && (!best_any || lv >= best_lvl)) begin
        best_idx = intc_pkg::IDX_W'(i);
        best_lvl = lv;
        best_any = 1'b1;
      end
    end
  end

  assign accept_src = best_any && (mode2 ? (best_lvl > mask_lvl) : !i_bit);
  assign accept_any = nmi_pend_reg || accept_src;

  // ****************************************************************************
  // nmi pin
  // ****************************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
      nmi_s3_reg <= 1'b0;
      nmi_level_reg <= 1'b0;
    end else begin
      nmi_s1_reg <= nmi_pin;
      nmi_s2_reg <= nmi_s1_reg;
      nmi_s3_reg <= nmi_s2_reg;
      if (nmi_s2_reg == nmi_s3_reg) begin
        nmi_level_reg <= nmi_s3_reg;
      end
    end
  end

  assign nmi_edge = (nmi_s2_reg == nmi_s3_reg) && (nmi_s3_reg != nmi_level_reg) &&
                    (nmi_s3_reg == ctrl_reg[intc_pkg::CTRL_NMI_EDGE_BIT]);

  // edge set wins over acceptance clear
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi_pend_reg <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend_reg <= 1'b1;
    end else if (state_reg == ST_IDLE && nmi_pend_reg) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  // ****************************************************************************
  // exception sequence
  // ****************************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      acc_nmi_reg <= 1'b0;
      acc_mode2_reg <= 1'b0;
      acc_lvl_reg <= 3'h0;
      acc_vec_reg <= 8'h00;
      ret_pc_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept_any) begin
            acc_nmi_reg <= nmi_pend_reg;
            acc_mode2_reg <= mode2;
            acc_lvl_reg <= nmi_pend_reg ? intc_pkg::NMI_MASK_LEVEL : best_lvl;
            acc_vec_reg <= nmi_pend_reg ? intc_pkg::NMI_VECTOR
                                        : intc_pkg::SRC_VECTOR[best_idx];
            state_reg <= ST_WAIT_INSN;
          end
        end
        ST_WAIT_INSN: begin
          if (insn_done) begin
            ret_pc_reg <= return_pc;
            state_reg <= ST_PUSH_PC;
          end
        end
        ST_PUSH_PC: state_reg <= ST_PUSH_CCR;
        ST_PUSH_CCR: state_reg <= acc_mode2_reg ? ST_PUSH_EXR : ST_MASK;
        ST_PUSH_EXR: state_reg <= ST_MASK;
        ST_MASK: state_reg <= ST_VEC;
        ST_VEC: begin
          if (vec_rd_ack) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // stack pushes, one per cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      push_valid_reg <= 1'b0;
      push_kind_reg <= intc_pkg::PUSH_PC;
      push_data_reg <= '0;
    end else begin
      push_valid_reg <= 1'b0;
      if (state_reg == ST_PUSH_PC) begin
        push_valid_reg <= 1'b1;
        push_kind_reg <= intc_pkg::PUSH_PC;
        push_data_reg <= ret_pc_reg;
      end else if (state_reg == ST_PUSH_CCR) begin
        push_valid_reg <= 1'b1;
        push_kind_reg <= intc_pkg::PUSH_CCR;
        push_data_reg <= PC_W'(ccr_reg);
      end else if (state_reg == ST_PUSH_EXR) begin
        push_valid_reg <= 1'b1;
        push_kind_reg <= intc_pkg::PUSH_EXR;
        push_data_reg <= PC_W'(exr_reg);
      end
    end
  end

  // vector fetch and jump
  always_ff @(posedge clk) begin
    if (rst) begin
      vec_rd_req_reg <= 1'b0;
      vec_addr_reg <= '0;
      jump_valid_reg <= 1'b0;
      jump_addr_reg <= '0;
    end else begin
      jump_valid_reg <= 1'b0;
      if (state_reg == ST_MASK) begin
        vec_rd_req_reg <= 1'b1;
        vec_addr_reg <= {6'h00, acc_vec_reg, 2'b00};
      end else if (state_reg == ST_VEC && vec_rd_ack) begin
        vec_rd_req_reg <= 1'b0;
        jump_valid_reg <= 1'b1;
        jump_addr_reg <= vec_rd_data;
      end
    end
  end

  // ****************************************************************************
  // wishbone slave
  // ****************************************************************************
  assign bus_req = cyc_i && stb_i && !ack_reg;
  assign bus_wr = bus_req && we_i;

  always_comb begin
    case (adr_i)
      intc_pkg::REG_CTRL: rd_value = {29'h0, ctrl_reg};
      intc_pkg::REG_CCR: rd_value = {24'h0, ccr_reg};
      intc_pkg::REG_EXR: rd_value = {24'h0, exr_reg};
      intc_pkg::REG_PRIO: rd_value = {8'h0, prio_reg};
      intc_pkg::REG_STAT: rd_value = {29'h0, stat_reg};
      intc_pkg::REG_MASK: rd_value = {29'h0, mask_reg};
      intc_pkg::REG_INFO: rd_value = {20'h0, 1'b0, acc_lvl_reg, acc_vec_reg};
      default: rd_value = 32'h0;
    endcase
  end

  assign wr_value = merge_lanes(rd_value, dat_i, sel_i);
  assign w1c_value = merge_lanes(32'h0, dat_i, sel_i);

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req;
      dat_reg <= (bus_req && !we_i) ? rd_value : 32'h0;
    end
  end

  // mode field only takes the two legal values
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= intc_pkg::CTRL_RESET;
      prio_reg <= intc_pkg::PRIO_RESET;
      mask_reg <= '0;
    end else if (bus_wr) begin
      if (adr_i == intc_pkg::REG_CTRL) begin
        ctrl_reg[2] <= wr_value[intc_pkg::CTRL_NMI_EDGE_BIT];
        if (wr_value[1:0] == intc_pkg::MODE_0 || wr_value[1:0] == intc_pkg::MODE_2) begin
          ctrl_reg[1:0] <= wr_value[1:0];
        end
      end
      if (adr_i == intc_pkg::REG_PRIO) begin
        prio_reg <= wr_value[23:0];
      end
      if (adr_i == intc_pkg::REG_MASK) begin
        mask_reg <= wr_value[intc_pkg::STAT_W-1:0];
      end
    end
  end

  // mask state: acceptance update wins over a software write
  always_ff @(posedge clk) begin
    if (rst) begin
      ccr_reg <= intc_pkg::CCR_RESET;
      exr_reg <= intc_pkg::EXR_RESET;
    end else if (state_reg == ST_MASK) begin
      if (!acc_mode2_reg) begin
        ccr_reg[intc_pkg::CCR_I_BIT] <= 1'b1;
      end else begin
        exr_reg[intc_pkg::EXR_T_BIT] <= 1'b0;
        exr_reg[2:0] <= acc_lvl_reg;
      end
    end else if (bus_wr) begin
      if (adr_i == intc_pkg::REG_CCR) begin
        ccr_reg <= wr_value[7:0];
      end
      if (adr_i == intc_pkg::REG_EXR) begin
        exr_reg <= {wr_value[7], 4'h0, wr_value[2:0]};
      end
    end
  end

  // ****************************************************************************
  // event status and interrupt output
  // ****************************************************************************
  always_comb begin
    stat_set = '0;
    stat_set[intc_pkg::STAT_ACCEPT] = (state_reg == ST_IDLE) && accept_any;
    stat_set[intc_pkg::STAT_NMI] = nmi_edge;
    stat_set[intc_pkg::STAT_HELD] = (state_reg == ST_IDLE) && best_any && !accept_any;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stat_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      if (bus_wr && adr_i == intc_pkg::REG_STAT) begin
        stat_reg <= (stat_reg & ~w1c_value[intc_pkg::STAT_W-1:0]) | stat_set;
      end else begin
        stat_reg <= stat_reg | stat_set;
      end
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign push_valid = push_valid_reg;
  assign push_kind = push_kind_reg;
  assign push_data = push_data_reg;
  assign vec_rd_req = vec_rd_req_reg;
  assign vec_addr = vec_addr_reg;
  assign jump_valid = jump_valid_reg;
  assign jump_addr = jump_addr_reg;
  assign irq = irq_reg;

  // ****************************************************************************
  // checks
  // ****************************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_vector_address: assert property ($rose(vec_rd_req) |->
    vec_addr == {6'h00, acc_vec_reg, 2'b00}) else $error("vector address not four times vector");
  chk_mode_legal: assert property (ctrl_reg[1:0] == intc_pkg::MODE_0 ||
    ctrl_reg[1:0] == intc_pkg::MODE_2) else $error("illegal control mode");
  chk_mode0_masked: assert property (state_reg == ST_IDLE && !mode2 && i_bit &&
    !nmi_pend_reg |=> state_reg == ST_IDLE) else $error("masked request accepted in mode 0");
  chk_request_enabled: assert property (state_reg == ST_IDLE && accept_src &&
    !nmi_pend_reg |-> src_flag[best_idx] && src_enable[best_idx]) else $error("disabled source won");
  chk_wait_insn: assert property (state_reg == ST_WAIT_INSN && !insn_done |=>
    state_reg == ST_WAIT_INSN && !push_valid) else $error("handling before instruction end");
  chk_push_order: assert property (push_valid && push_kind == intc_pkg::PUSH_PC |=>
    push_valid && push_kind == intc_pkg::PUSH_CCR) else $error("ccr push missing after pc");
  chk_exr_push: assert property (push_valid && push_kind == intc_pkg::PUSH_CCR &&
    acc_mode2_reg |=> push_valid && push_kind == intc_pkg::PUSH_EXR) else $error("exr push missing");
  chk_mode0_ibit: assert property (state_reg == ST_MASK && !acc_mode2_reg |=>
    i_bit ##1 vec_rd_req) else $error("mask bit not set after stacking");
  chk_mode2_level: assert property (state_reg == ST_MASK && acc_mode2_reg |=>
    mask_lvl == $past(acc_lvl_reg) && !exr_reg[intc_pkg::EXR_T_BIT]) else $error("mask level wrong");
  chk_nmi_level: assert property (state_reg == ST_MASK && acc_mode2_reg && acc_nmi_reg |=>
    mask_lvl == 3'h7) else $error("nmi mask level not seven");
  chk_mode2_strict: assert property (state_reg == ST_IDLE && mode2 && !nmi_pend_reg &&
    best_lvl <= mask_lvl |=> state_reg == ST_IDLE) else $error("level not above mask accepted");
  chk_jump_target: assert property (vec_rd_req && vec_rd_ack |=>
    jump_valid && jump_addr == $past(vec_rd_data)) else $error("jump target differs from entry");

  cov_mode0_accept: cover property (state_reg == ST_MASK && !acc_mode2_reg ##1 ccr_reg[7]);
  cov_mode2_accept: cover property (push_kind == intc_pkg::PUSH_EXR && push_valid);
  cov_nmi_taken: cover property (nmi_edge ##[1:20] jump_valid);

endmodule

// ===== vector_mem_model.sv
// vector table memory model on the far side of the controller
// assumes vec_rd_req is a level held until vec_rd_ack is sampled high
`timescale 1ns/1ps
module vector_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic vec_rd_req,
  input wire logic [intc_pkg::HANDLER_W-1:0] vec_addr,
  output logic vec_rd_ack,
  output logic [intc_pkg::HANDLER_W-1:0] vec_rd_data
);
  // ****************************************************************************
  // answer: handler is the inverted entry address; data toggles when not valid
  // ****************************************************************************
  logic [1:0] wait_reg;
  always @(posedge clk) begin
    if (rst) begin
      vec_rd_ack <= 1'b0;
      vec_rd_data <= 16'h0000;
      wait_reg <= 2'h0;
    end else if (vec_rd_req && !vec_rd_ack && (!slow || wait_reg == 2'h3)) begin
      vec_rd_ack <= 1'b1;
      vec_rd_data <= ~vec_addr;
      wait_reg <= 2'h0;
    end else begin
      vec_rd_ack <= 1'b0;
      vec_rd_data <= ~vec_rd_data;
      if (vec_rd_req && !vec_rd_ack) begin
        wait_reg <= wait_reg + 2'h1;
      end
    end
  end
endmodule

// ===== priority_interrupt_controller_tb.sv
// self-checking testbench of the priority interrupt controller
// assumes intc_pkg, the design and vector_mem_model are compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); mismatches++; end end
module priority_interrupt_controller_tb;
  // ****************************************************************************
  // signals and instances
  // ****************************************************************************
  logic clk = 0, rst = 1, we_i = 0, cyc_i = 0, stb_i = 0, nmi_pin = 0, insn_done = 0;
  logic slow = 0, ack_o, push_valid, vec_rd_req, vec_rd_ack, jump_valid, irq;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [3:0] sel_i = 4'h0;
  logic [20:0] src_flag = 21'h0, src_enable = 21'h0;
  logic [23:0] return_pc = 24'h0, push_data;
  logic [1:0] push_kind;
  logic [15:0] vec_addr, vec_rd_data, jump_addr, last_jump;
  logic [25:0] pq[$];
  int mismatches = 0, checks_done = 0, jumps = 0;
  always #2.5 clk = ~clk;
  priority_interrupt_controller i_dut (.clk(clk), .rst(rst), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .nmi_pin(nmi_pin), .src_flag(src_flag), .src_enable(src_enable), .insn_done(insn_done),
    .return_pc(return_pc), .push_valid(push_valid), .push_kind(push_kind),
    .push_data(push_data), .vec_rd_req(vec_rd_req), .vec_addr(vec_addr),
    .vec_rd_ack(vec_rd_ack), .vec_rd_data(vec_rd_data), .jump_valid(jump_valid),
    .jump_addr(jump_addr), .irq(irq));
  vector_mem_model i_mem (.clk(clk), .rst(rst), .slow(slow), .vec_rd_req(vec_rd_req),
    .vec_addr(vec_addr), .vec_rd_ack(vec_rd_ack), .vec_rd_data(vec_rd_data));
  always @(posedge clk) begin
    if (push_valid === 1'b1) pq.push_back({push_kind, push_data});
    if (jump_valid === 1'b1) begin
      jumps++;
      last_jump = jump_addr;
    end
  end
  // ****************************************************************************
  // shared tasks
  // ****************************************************************************
  task print_verdict;
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task fail_out;
    mismatches++;
    print_verdict;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) fail_out;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    wb(1'b0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask
  task pulse_done;
    insn_done <= 1'b1;
    @(posedge clk);
    insn_done <= 1'b0;
  endtask
  task idle_chk(input string nm);
    pq.delete();
    repeat (8) @(posedge clk);
    pulse_done;
    repeat (10) @(posedge clk);
    `CHK(nm, 0, pq.size())
  endtask
  task exc(input logic [7:0] v, input logic m2, input logic [7:0] condition_code_register, input logic [7:0] extended_control_register);
    int n;
    int j0;
    n = 0;
    j0 = jumps;
    pq.delete();
    repeat (6) @(posedge clk);
    `CHK("early push", 0, pq.size())
    return_pc <= 24'h012340 + v;
    pulse_done;
    while (jumps == j0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (n >= 60) fail_out;
    `CHK("push count", m2 ? 3 : 2, pq.size())
    `CHK("push pc", {2'h0, 24'h012340 + v}, pq[0])
    `CHK("push ccr", {2'h1, 16'h0000, condition_code_register}, pq[1])
    if (m2) `CHK("push exr", {2'h2, 16'h0000, extended_control_register}, pq[2])
    `CHK("handler", ~{6'h00, v, 2'h0}, last_jump)
  endtask
  // ****************************************************************************
  // scenarios
  // ****************************************************************************
  task t_reset;
    rdchk("ctrl", intc_pkg::REG_CTRL, 32'h0);
    rdchk("ccr", intc_pkg::REG_CCR, 32'h80);
    rdchk("exr", intc_pkg::REG_EXR, 32'h07);
    rdchk("prio", intc_pkg::REG_PRIO, 32'h0);
    rdchk("unmapped", 8'h40, 32'h0);
  endtask
  task t_mode0;
    src_enable <= 21'h000210;
    src_flag <= 21'h000212;
    idle_chk("masked");
    wb(1'b1, intc_pkg::REG_CCR, 32'h0);
    exc(8'h49, 1'b0, 8'h00, 8'h00);
    rdchk("ccr set", intc_pkg::REG_CCR, 32'h80);
    src_flag <= 21'h0;
  endtask
  task t_mode2;
    wb(1'b1, intc_pkg::REG_CTRL, 32'h2);
    wb(1'b1, intc_pkg::REG_CTRL, 32'h1);
    rdchk("mode keep", intc_pkg::REG_CTRL, 32'h2);
    wb(1'b1, intc_pkg::REG_PRIO, 32'h005520);
    wb(1'b1, intc_pkg::REG_EXR, 32'h82);
    slow <= 1'b1;
    src_enable <= 21'h000910;
    src_flag <= 21'h000910;
    exc(8'h51, 1'b1, 8'h80, 8'h82);
    rdchk("exr level", intc_pkg::REG_EXR, 32'h05);
    src_flag <= 21'h000810;
    idle_chk("level held");
    wb(1'b1, intc_pkg::REG_EXR, 32'h04);
    exc(8'h54, 1'b1, 8'h80, 8'h04);
    src_flag <= 21'h0;
  endtask
  task t_nmi;
    wb(1'b1, intc_pkg::REG_CTRL, 32'h6);
    rdchk("ctrl edge", intc_pkg::REG_CTRL, 32'h6);
    wb(1'b1, intc_pkg::REG_EXR, 32'h87);
    nmi_pin <= 1'b1;
    exc(8'h07, 1'b1, 8'h80, 8'h87);
    rdchk("exr nmi", intc_pkg::REG_EXR, 32'h07);
    rdchk("info nmi", intc_pkg::REG_INFO, 32'h707);
    nmi_pin <= 1'b0;
    idle_chk("wrong edge");
  endtask
  task t_irq;
    wb(1'b0, intc_pkg::REG_STAT, 32'h0);
    `CHK("stat", 32'h7, rd & 32'h7)
    @(negedge clk);
    `CHK("irq masked", 1'b0, irq)
    wb(1'b1, intc_pkg::REG_MASK, 32'h2);
    repeat (3) @(negedge clk);
    `CHK("irq on", 1'b1, irq)
    wb(1'b1, intc_pkg::REG_STAT, 32'h2);
    repeat (3) @(negedge clk);
    `CHK("irq clear", 1'b0, irq)
  endtask
  // ****************************************************************************
  // main sequence
  // ****************************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_mode0;
    t_mode2;
    t_nmi;
    t_irq;
    print_verdict;
  end
  initial begin
    #100000;
    fail_out;
  end
endmodule
